// >>> hw/ils_scanner.sv
/*
  Input line scanner: scans the message-ready lines of the tape reader
  substations, connects one reader to reader control, turns each character
  contact closure into a pulse and forwards it through a FIFO to the code
  translator until end of message or a character time-out.
  Assumes all substation and translator signals except xlat_ready_in are asynchronous pins, and
  that a reader presents its character lines stable before its strobe.
//
// Overview of operation
// RULE_01: Step through request lines until one ready
// RULE_02: Up to sixteen substations, all scanned
// RULE_03: Step lines at a 25 KC rate
// RULE_04: Hold reader path until message done
// RULE_05: One message per selection, then move on
// RULE_06: Reader skips leader, halts, raises request
// RULE_07: Tape-stored detector starts reader on tape
// RULE_08: Read command only to selected, reader waits
// RULE_09: Read characters, pulse them, forward onward
// RULE_10: Multiplexer passes data reader to control only
// RULE_11: End of message disconnects, scan restarts
// RULE_12: Time-out abandons message, releases scanner
// RULE_13: Punch fills after end-of-message sequence
// RULE_14: Translator latches, checks parity, encodes character
// RULE_15: No request, no transfer: idle, unconnected
*/
`timescale 1ns/1ps
`include "ils_defines.svh"
module ils_scanner #(
    parameter int unsigned STEP_DIV = `ILS_STEP_DIV
) (
    // Clock and reset
    input  wire logic                                 ref_clk_in,
    input  wire logic                                 reset_n_in,
    // Substation readers
    input  wire logic [`ILS_NUM_SUB-1:0]              msg_ready_in,
    input  wire ils_pkg::ils_char_t [`ILS_NUM_SUB-1:0] reader_char_in,
    input  wire logic [`ILS_NUM_SUB-1:0]              reader_strobe_in,
    output logic [`ILS_NUM_SUB-1:0]                   read_cmd_out,
    // Translator
    output ils_pkg::ils_char_t                        xlat_char_out,
    output logic                                      xlat_valid_out,
    input  wire logic                                 xlat_ready_in,
    input  wire logic                                 eom_in,
    input  wire logic                                 timeout_in,
    // Status
    output logic                                      busy_out,
    output logic [`ILS_SEL_W-1:0]                     sel_out
);
    localparam logic [`ILS_DIV_W-1:0] STEP_LAST = `ILS_DIV_W'(STEP_DIV - 1);

    logic                            rst_s1_r;
    logic                            rst_n_r;
    logic [`ILS_NUM_SUB-1:0]         req_s1_r;
    logic [`ILS_NUM_SUB-1:0]         req_s2_r;
    logic [`ILS_NUM_SUB-1:0]         stb_s1_r;
    logic [`ILS_NUM_SUB-1:0]         stb_s2_r;
    ils_pkg::ils_char_t [`ILS_NUM_SUB-1:0] chr_s1_r;
    ils_pkg::ils_char_t [`ILS_NUM_SUB-1:0] chr_s2_r;
    logic [1:0]                      eom_s_r;
    logic [1:0]                      to_s_r;
    logic                            eom_d_r;
    logic                            to_d_r;
    logic                            eom_pulse;
    logic                            to_pulse;
    logic [`ILS_DIV_W-1:0]           div_cnt_r;
    logic                            step_en;
    ils_pkg::ils_state_t             state_r;
    logic [`ILS_SEL_W-1:0]           idx_r;
    logic [`ILS_SEL_W-1:0]           sel_r;
    logic                            stb_sel;
    logic                            stb_d_r;
    logic                            char_pulse;
    logic                            pend_valid_r;
    ils_pkg::ils_char_t              pend_char_r;
    logic                            fifo_in_ready;
    logic                            found;
    logic                            release_link;
    logic [`ILS_DIV_W-1:0]           gap_cnt_r;
    logic                            gap_seen_r;
    logic [`ILS_SEL_W-1:0]           idx_d_r;
    logic                            abandon;

    // Reset release
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Pin synchronisers
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            stb_s1_r <= '0;
            stb_s2_r <= '0;
            chr_s1_r <= '0;
            chr_s2_r <= '0;
            eom_s_r  <= 2'h0;
            to_s_r   <= 2'h0;
        end else begin
            req_s1_r <= msg_ready_in;
            req_s2_r <= req_s1_r;
            stb_s1_r <= reader_strobe_in;
            stb_s2_r <= stb_s1_r;
            chr_s1_r <= reader_char_in;
            chr_s2_r <= chr_s1_r;
            eom_s_r  <= {eom_s_r[0], eom_in};
            to_s_r   <= {to_s_r[0], timeout_in};
        end
    end

    // Edge detect of translator signals
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            eom_d_r <= 1'b0;
            to_d_r  <= 1'b0;
        end else begin
            eom_d_r <= eom_s_r[1];
            to_d_r  <= to_s_r[1];
        end
    end

    assign eom_pulse = eom_s_r[1] && !eom_d_r;
    assign to_pulse  = to_s_r[1] && !to_d_r;

    // Stepping rate divider
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_cnt_r <= '0;
        end else if (state_r != ils_pkg::ILS_SCAN || step_en) begin
            div_cnt_r <= '0; // [RULE_03]
        end else begin
            div_cnt_r <= `ILS_DIV_W'(div_cnt_r + 1'b1);
        end
    end

    assign step_en      = (state_r == ils_pkg::ILS_SCAN) && (div_cnt_r == STEP_LAST);
    assign found        = step_en && req_s2_r[idx_r];
    assign release_link = (state_r == ils_pkg::ILS_LINK) && (eom_pulse || to_pulse);
    // A time-out outside a connection must not drop a finished message still draining
    assign abandon      = (state_r == ils_pkg::ILS_LINK) && to_pulse; // [RULE_12]

    // Scanner state
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ils_pkg::ILS_IDLE;
        end else begin
            case (state_r)
                ils_pkg::ILS_IDLE: begin
                    if (req_s2_r != '0) begin
                        state_r <= ils_pkg::ILS_SCAN; // [RULE_01]
                    end
                end
                ils_pkg::ILS_SCAN: begin
                    if (found) begin
                        state_r <= ils_pkg::ILS_LINK; // [RULE_04]
                    end else if (req_s2_r == '0) begin
                        state_r <= ils_pkg::ILS_IDLE; // [RULE_15]
                    end
                end
                ils_pkg::ILS_LINK: begin
                    if (release_link) begin
                        state_r <= ils_pkg::ILS_IDLE; // [RULE_11] [RULE_12]
                    end
                end
                default: begin
                    state_r <= ils_pkg::ILS_IDLE;
                end
            endcase
        end
    end

    // Scan position; the line after a served one is probed first
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            idx_r <= '0;
            sel_r <= '0;
        end else if (found) begin
            sel_r <= idx_r; // [RULE_04]
        end else if (step_en) begin
            idx_r <= `ILS_SEL_W'(idx_r + 1'b1); // [RULE_01] [RULE_02]
        end else if (release_link) begin
            idx_r <= `ILS_SEL_W'(sel_r + 1'b1); // [RULE_05]
        end
    end

    // One-way multiplexer: only the selected reader's lines are looked at
    assign stb_sel = stb_s2_r[sel_r]; // [RULE_10]

    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stb_d_r <= 1'b1;
        end else if (state_r != ils_pkg::ILS_LINK) begin
            stb_d_r <= 1'b1;
        end else begin
            stb_d_r <= stb_sel;
        end
    end

    // A contact closure becomes a one-cycle character pulse
    assign char_pulse = (state_r == ils_pkg::ILS_LINK) && stb_sel && !stb_d_r; // [RULE_09]

    // Character held until the FIFO takes it; capture wins over the push
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pend_valid_r <= 1'b0;
            pend_char_r  <= '0;
        end else if (char_pulse) begin
            pend_valid_r <= 1'b1; // [RULE_09]
            pend_char_r  <= chr_s2_r[sel_r]; // [RULE_10]
        end else if (abandon) begin
            pend_valid_r <= 1'b0; // [RULE_12]
        end else if (fifo_in_ready) begin
            pend_valid_r <= 1'b0;
        end
    end

    // Read command to the selected reader only, withheld under back-pressure
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            read_cmd_out <= '0;
        end else if (state_r == ils_pkg::ILS_LINK && !release_link &&
                     !pend_valid_r && !char_pulse && fifo_in_ready) begin
            read_cmd_out <= `ILS_NUM_SUB'(1) << sel_r; // [RULE_08]
        end else begin
            read_cmd_out <= '0; // [RULE_15]
        end
    end

    ils_fifo #(
        .WIDTH (`ILS_CHAR_W),
        .DEPTH (`ILS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (ref_clk_in),
        .rst_n_in      (rst_n_r),
        .flush_in      (abandon),
        .in_valid_in   (pend_valid_r),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (pend_char_r),
        .out_valid_out (xlat_valid_out),
        .out_ready_in  (xlat_ready_in),
        .out_data_out  (xlat_char_out)
    );

    assign busy_out = (state_r != ils_pkg::ILS_IDLE);
    assign sel_out  = sel_r;

    // Cycles since the scan position last moved, counted apart from the divider
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            gap_cnt_r  <= '0;
            gap_seen_r <= 1'b0;
            idx_d_r    <= '0;
        end else begin
            idx_d_r <= idx_r;
            if (state_r != ils_pkg::ILS_SCAN) begin
                gap_cnt_r  <= '0;
                gap_seen_r <= 1'b0;
            end else if (idx_r != idx_d_r) begin
                gap_cnt_r  <= '0;
                gap_seen_r <= 1'b1;
            end else begin
                gap_cnt_r <= `ILS_DIV_W'(gap_cnt_r + 1'b1);
            end
        end
    end

    cmd_onehot_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_08]
        (read_cmd_out != '0) |-> (read_cmd_out == (`ILS_NUM_SUB'(1) << sel_r)))
        else $error("read command not on the selected line");

    cmd_in_link_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_04]
        (read_cmd_out != '0) |-> $past(state_r) == ils_pkg::ILS_LINK)
        else $error("read command outside a connection");

    idle_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_15]
        (state_r == ils_pkg::ILS_IDLE) ##1 (state_r == ils_pkg::ILS_IDLE)
        |-> (read_cmd_out == '0) && !busy_out)
        else $error("idle scanner drives a reader");

    step_period_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_03]
        (state_r == ils_pkg::ILS_SCAN && gap_seen_r && idx_r != idx_d_r)
        |-> (gap_cnt_r == STEP_LAST))
        else $error("stepping period wrong");

    scan_advance_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_02]
        (step_en && !req_s2_r[idx_r]) |=> (idx_r == `ILS_SEL_W'($past(idx_r) + 1'b1)))
        else $error("scan did not move to the next line");

    found_link_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_01]
        found |=> (state_r == ils_pkg::ILS_LINK) && (sel_r == $past(idx_r)))
        else $error("ready substation not connected");

    eom_release_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_11]
        (state_r == ils_pkg::ILS_LINK && eom_pulse)
        |=> (state_r == ils_pkg::ILS_IDLE) ##1 (read_cmd_out == '0))
        else $error("end of message did not disconnect");

    timeout_flush_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_12]
        (state_r == ils_pkg::ILS_LINK && to_pulse && !char_pulse)
        |=> !xlat_valid_out && !pend_valid_r && !busy_out)
        else $error("time-out did not abandon the message");

    next_first_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_05]
        release_link |=> (idx_r == `ILS_SEL_W'($past(sel_r) + 1'b1)))
        else $error("served substation not passed over");

    char_capture_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // [RULE_09]
        char_pulse |=> pend_valid_r && (pend_char_r == $past(chr_s2_r[sel_r])))
        else $error("character pulse not captured");
endmodule

// >>> inc/ils_defines.svh
/*
  Constants of the input line scanner: substation count, clock and stepping
  rates, character width and FIFO depth.
  Assumes inclusion by bare name from design files.
*/
`ifndef ILS_DEFINES_SVH
`define ILS_DEFINES_SVH

`define ILS_NUM_SUB      16
`define ILS_SEL_W        4
`define ILS_CHAR_W       6
`define ILS_FIFO_DEPTH   8
`define ILS_CLK_FREQ_HZ  125000000
`define ILS_STEP_FREQ_HZ 25000
`define ILS_STEP_DIV     (`ILS_CLK_FREQ_HZ / `ILS_STEP_FREQ_HZ)
`define ILS_DIV_W        13

`endif

// >>> inc/ils_pkg.sv
/*
  Types of the input line scanner: the tape character and the scanner states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ils_pkg;

    // Five-level code plus the parity level punched by the substation
    typedef struct packed {
        logic       parity;
        logic [4:0] code;
    } ils_char_t;

    typedef enum logic [1:0] {
        ILS_IDLE = 2'b00,
        ILS_SCAN = 2'b01,
        ILS_LINK = 2'b10
    } ils_state_t;

endpackage

// >>> hw/ils_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/1ps
module ils_fifo #(
    parameter int unsigned WIDTH = 6,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             flush_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_r != (PW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = mem_r[rd_ptr_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (flush_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr_r + 1'b1);
            end
            if (push && !pop) begin
                count_r <= (PW+1)'(count_r + 1'b1);
            end else if (pop && !push) begin
                count_r <= (PW+1)'(count_r - 1'b1);
            end
        end
    end
endmodule

// >>> tb/ils_partner.sv
/*
  Behavioural far side of the scanner: sixteen tape reader substations and
  the code translator, with stall and abort controls for the testbench.
  Assumes the port set of ils_scanner and stimulus on the falling edge.
*/
`timescale 1ns/1ps
module ils_partner #(
    parameter int LEN = 10
) (
    // Clock and testbench controls
    input  wire logic                     clk_in,
    input  wire logic                     stall_in,
    input  wire logic                     abort_in,
    // Scanner side
    input  wire logic [15:0]              read_cmd_in,
    input  wire ils_pkg::ils_char_t       xlat_char_in,
    input  wire logic                     xlat_valid_in,
    input  wire logic [3:0]               sel_in,
    // Substations and translator
    output logic [15:0]                   msg_ready_out,
    output ils_pkg::ils_char_t [15:0]     char_out,
    output logic [15:0]                   strobe_out,
    output logic                          xlat_ready_out,
    output logic                          eom_out,
    output logic                          timeout_out
);
    int                 pend[16] = '{default: 0};
    int                 pos[16] = '{default: 0};
    int                 cnt[16] = '{default: 0};
    int                 rx_n = 0;
    int                 hold = 0;
    int                 perr = 0;
    logic [4:0]         c5;
    ils_pkg::ils_char_t rx_q[$];

    initial begin
        msg_ready_out = '0;
        char_out = '0;
        strobe_out = '0;
        xlat_ready_out = 1'b0;
        eom_out = 1'b0;
        timeout_out = 1'b0;
    end

    always @(negedge clk_in) begin
        for (int i = 0; i < 16; i++) begin
            // The ready line is raised while at least one stored message is pending
            msg_ready_out[i] <= pend[i] > 0;
            if (strobe_out[i] && !read_cmd_in[i]) begin
                // Character taken: open the contact, scramble the lines
                strobe_out[i] <= 1'b0;
                char_out[i] <= ~char_out[i];
                pos[i]++;
                cnt[i] = 0;
            end else if (read_cmd_in[i] && !strobe_out[i] && pos[i] < LEN) begin
                c5 = 5'({4'(i), 1'(pos[i])});
                if (cnt[i] == 0)
                    char_out[i] <= {^c5, c5};
                cnt[i]++;
                if (cnt[i] > 4)
                    strobe_out[i] <= 1'b1;
            end
        end
        if (hold > 0)
            hold--;
        if (hold == 0) begin
            eom_out <= 1'b0;
            timeout_out <= 1'b0;
        end
        if (hold == 0 && (rx_n == LEN || (abort_in && rx_n == 2))) begin
            eom_out <= rx_n == LEN;
            timeout_out <= rx_n != LEN;
            hold = 6;
            rx_n = 0;
            pend[sel_in]--;
            pos[sel_in] = 0;
            cnt[sel_in] = 0;
            strobe_out[sel_in] <= 1'b0;
        end
        xlat_ready_out <= !stall_in && hold == 0;
    end

    always @(posedge clk_in) begin
        if (xlat_valid_in && xlat_ready_out) begin
            rx_q.push_back(xlat_char_in);
            rx_n++;
            if (xlat_char_in.parity !== ^xlat_char_in.code)
                perr++;
        end
    end
endmodule

// >>> tb/ils_scanner_tb.sv
/*
  Testbench of the input line scanner: idle state, one message, round robin,
  FIFO fill and drain, and character time-out.
  Assumes ils_partner for the substations and the translator.
*/
`timescale 1ns/1ps
`include "ils_defines.svh"
module ils_scanner_tb;
    localparam int SD = 8;
    localparam int LEN = 10;
    logic                      ref_clk = 1'b0;
    logic                      rst_n = 1'b0;
    logic                      stall = 1'b0;
    logic                      abort = 1'b0;
    logic [15:0]               msg_ready;
    logic [15:0]               strobe;
    logic [15:0]               read_cmd;
    ils_pkg::ils_char_t [15:0] chars;
    ils_pkg::ils_char_t        xchar;
    logic                      xvalid;
    logic                      xready;
    logic                      eom;
    logic                      tmo;
    logic                      busy;
    logic [3:0]                sel;
    int                        mismatches = 0;
    int                        cmp_count = 0;

    initial forever #4 ref_clk = ~ref_clk;

    ils_scanner #(.STEP_DIV(SD)) u_ils_scanner (
        .ref_clk_in(ref_clk), .reset_n_in(rst_n), .msg_ready_in(msg_ready),
        .reader_char_in(chars), .reader_strobe_in(strobe), .read_cmd_out(read_cmd),
        .xlat_char_out(xchar), .xlat_valid_out(xvalid), .xlat_ready_in(xready),
        .eom_in(eom), .timeout_in(tmo), .busy_out(busy), .sel_out(sel));

    ils_partner #(.LEN(LEN)) u_ils_partner (
        .clk_in(ref_clk), .stall_in(stall), .abort_in(abort), .read_cmd_in(read_cmd),
        .xlat_char_in(xchar), .xlat_valid_in(xvalid), .sel_in(sel),
        .msg_ready_out(msg_ready), .char_out(chars), .strobe_out(strobe),
        .xlat_ready_out(xready), .eom_out(eom), .timeout_out(tmo));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t ns: %s is %0h, not %0h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s ended, %0d mismatches so far", s, mismatches);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        repeat (3) @(negedge ref_clk);
        while ((busy !== 1'b0 || msg_ready !== 16'h0) && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 5000, 1, "completion wait");
    endtask

    // Characters arrive whole, in order, message after message
    task automatic check_rx(input int subs[$], input int n);
        check(u_ils_partner.rx_q.size(), subs.size() * n, "character count");
        foreach (u_ils_partner.rx_q[k])
            check(u_ils_partner.rx_q[k].code, 5'({4'(subs[k / n]), 1'(k % n)}), "char");
        check(u_ils_partner.perr, 0, "parity");
        u_ils_partner.rx_q.delete();
    endtask

    // Only the selected substation may see a read command
    always @(negedge ref_clk) begin
        if (rst_n && read_cmd !== 16'h0)
            check(read_cmd, 16'h1 << sel, "read command target");
    end

    task automatic t_single();
        int n;
        n = 0;
        check({busy, xvalid, read_cmd, sel}, 0, "idle outputs");
        u_ils_partner.pend[5] += 1;
        while (busy !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (read_cmd[5] !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        check(n >= 5 * SD && n <= 6 * SD + 4, 1, "steps to line 5");
        wait_done();
        check_rx({5}, LEN);
        check({busy, read_cmd, sel}, 5, "released");
        done("single");
    endtask

    task automatic t_round();
        u_ils_partner.pend[1] += 2;
        u_ils_partner.pend[5] += 1;
        u_ils_partner.pend[15] += 1;
        wait_done();
        check_rx({15, 1, 5, 1}, LEN);
        done("round");
    endtask

    task automatic t_fill();
        int n;
        n = 0;
        stall = 1'b1;
        u_ils_partner.pend[3] += 1;
        while (u_ils_partner.pos[3] < `ILS_FIFO_DEPTH && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (40) @(negedge ref_clk);
        check(u_ils_partner.pos[3], `ILS_FIFO_DEPTH, "chars taken while stalled");
        check({read_cmd, xvalid}, 1, "full refuses reader");
        stall = 1'b0;
        wait_done();
        check_rx({3}, LEN);
        check(xvalid, 0, "drained");
        done("fill");
    endtask

    task automatic t_abort();
        abort = 1'b1;
        u_ils_partner.pend[9] += 1;
        wait_done();
        check_rx({9}, 2);
        check(xvalid, 0, "flushed");
        abort = 1'b0;
        u_ils_partner.pend[2] += 1;
        wait_done();
        check_rx({2}, LEN);
        done("abort");
    endtask

    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        t_single();
        t_round();
        t_fill();
        t_abort();
        summarize();
    end
endmodule
